// File: include/lcp_pkg.sv
// Shared constants for the LCD controller host port and display RAM map
package lcp_pkg;

  // ****************************************
  // Status byte field positions
  // ****************************************
  localparam int STA_CMD_READY   = 0;
  localparam int STA_DATA_READY  = 1;
  localparam int STA_AUTO_RD     = 2;
  localparam int STA_AUTO_WR     = 3;
  localparam int STA_UNUSED      = 4;
  localparam int STA_OPERABLE    = 5;
  localparam int STA_PEEK_ERR    = 6;
  localparam int STA_BLINK       = 7;

  // ****************************************
  // Display RAM map
  // ****************************************
  localparam logic [15:0] SINGLE_TOP       = 16'hffff;
  localparam logic [15:0] UPPER_BASE       = 16'h0000;
  localparam logic [15:0] UPPER_TOP        = 16'h7fff;
  localparam logic [15:0] LOWER_BASE       = 16'h8000;
  localparam logic [15:0] LOWER_TOP        = 16'hffff;
  localparam int          PANEL_SEL_BIT    = 15;
  localparam logic [15:0] SEL_LOW_TOP      = 16'h07ff;
  localparam logic [15:0] SEL_HIGH_BASE    = 16'h0800;
  localparam logic [15:0] SEL_HIGH_TOP     = 16'h0fff;

  // ****************************************
  // Command coding used by the sequencer
  // ****************************************
  localparam logic [7:0] CMD_AUTO_WRITE    = 8'hb0;
  localparam logic [7:0] CMD_AUTO_READ     = 8'hb1;
  localparam logic [7:0] CMD_AUTO_RESET    = 8'hb2;
  localparam logic [7:0] CMD_PEEK          = 8'he0;
  localparam logic [7:0] CMD_COPY          = 8'he8;
  localparam logic [7:0] CMD_DISP_MASK     = 8'hf0;
  localparam logic [7:0] CMD_DISP_CODE     = 8'h90;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam int          CLK_NS           = 4;
  localparam int          BUSY_CYC         = 4;
  localparam int          LINE_CYC         = 64;
  localparam int          CALC_CYC         = 8;
  localparam int          PULSE_NS         = 80;
  localparam int          PULSE_CYC        = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Host command register map (word addresses)
  // ****************************************
  localparam logic [3:0] REG_CTRL          = 4'h0;
  localparam logic [3:0] REG_DATA          = 4'h1;
  localparam logic [3:0] REG_STAT          = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT      = 4'h3;
  localparam logic [3:0] REG_IRQ_MASK      = 4'h4;
  localparam int         CTRL_GO           = 0;
  localparam int         CTRL_CD           = 1;
  localparam int         CTRL_RD           = 2;
  localparam int         IRQ_DONE          = 0;
  localparam int         IRQ_ERR           = 1;

endpackage

// File: include/lcp_if.sv
// Parallel host port between controller and microprocessor
`timescale 1ns/1ps
interface lcp_if;
  logic       ce_n;
  logic       rd_n;
  logic       wr_n;
  logic       cd;
  logic [7:0] host_d;
  logic       host_oe;
  logic [7:0] dev_d;
  logic       dev_oe;

  modport dev (
    input  ce_n,
    input  rd_n,
    input  wr_n,
    input  cd,
    input  host_d,
    input  host_oe,
    output dev_d,
    output dev_oe
  );

  modport host (
    output ce_n,
    output rd_n,
    output wr_n,
    output cd,
    output host_d,
    output host_oe,
    input  dev_d,
    input  dev_oe
  );
endinterface

// File: hw/lcp_dev.sv
// Controller end: status byte, parameter capture, command sequencing, RAM map
//
// Summary of operation
// - Single scan uses full 64 KB freely
// - Dual scan: upper low half, lower high
// - Lower panel differs only by top address
// - Two memory selects for 2 KB regions
// - Status read places status byte on bus
// - Host checks status before each data transfer
// - Bit0 command ready, bit1 data ready
// - Bit2 auto read, bit3 auto write ready
// - Bit5 operable, bit4 unused zero
// - Bit6 flags peek or copy error
// - Bit7 zero when display off
// - Host checks bits 0 and 1 together
// - Auto mode: only auto bits valid
// - Host reads status before top-zero commands
// - Top-zero command during line calc waits
// - Host checks status after wait state
// - Host sends parameters before command byte
// - Extra parameters: last one or two used
`timescale 1ns/1ps
module lcp_dev (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  lcp_if.dev               bus,
  input  wire logic        dual_scan_i,
  input  wire logic        enable_i,
  input  wire logic        peek_fault_i,
  input  wire logic [15:0] scan_addr_i,
  input  wire logic        scan_lower_i,
  output logic      [15:0] ram_addr_o,
  output logic             mem_select_low_region_o,
  output logic             mem_select_high_region_o,
  output logic      [7:0]  cmd_o,
  output logic      [7:0]  param0_o,
  output logic      [7:0]  param1_o,
  output logic             cmd_valid_o,
  output logic      [7:0]  wdata_o,
  output logic             wdata_valid_o
);

  typedef enum logic [1:0] {
    LCP_IDLE = 2'b00,
    LCP_BUSY = 2'b01,
    LCP_WAIT = 2'b10
  } lcp_state_e;

  // ****************************************
  // Host strobe edge detection
  // ****************************************
  logic       wr_act;
  logic       rd_act;
  logic       wr_prev_r;
  logic       wr_prev_nxt;
  logic       wr_rise;

  assign wr_act      = !bus.ce_n && !bus.wr_n;
  assign rd_act      = !bus.ce_n && !bus.rd_n;
  assign wr_prev_nxt = wr_act;
  assign wr_rise     = wr_prev_r && !wr_act;

  // ****************************************
  // Sequencer state
  // ****************************************
  lcp_state_e state_r;
  lcp_state_e state_nxt;
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  logic [7:0] line_cnt_r;
  logic [7:0] line_cnt_nxt;
  logic [7:0] held_cmd_r;
  logic [7:0] held_cmd_nxt;
  logic [7:0] p0_r;
  logic [7:0] p0_nxt;
  logic [7:0] p1_r;
  logic [7:0] p1_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic       cmd_vld_r;
  logic       cmd_vld_nxt;
  logic [7:0] wd_r;
  logic [7:0] wd_nxt;
  logic       wd_vld_r;
  logic       wd_vld_nxt;
  logic       auto_rd_r;
  logic       auto_rd_nxt;
  logic       auto_wr_r;
  logic       auto_wr_nxt;
  logic       err_r;
  logic       err_nxt;
  logic       disp_on_r;
  logic       disp_on_nxt;
  logic       calc;
  logic [7:0] in_byte;

  assign calc    = line_cnt_r >= 8'(lcp_pkg::LINE_CYC - lcp_pkg::CALC_CYC);
  assign in_byte = bus.host_d;

  // Issue a command byte: decode auto, peek/copy and display-off effects
  function automatic logic is_auto(input logic [7:0] c);
    is_auto = (c == lcp_pkg::CMD_AUTO_READ) || (c == lcp_pkg::CMD_AUTO_WRITE);
  endfunction

  always_comb begin
    state_nxt    = state_r;
    busy_cnt_nxt = busy_cnt_r;
    line_cnt_nxt = (line_cnt_r == 8'(lcp_pkg::LINE_CYC - 1)) ? 8'h00 : line_cnt_r + 8'h01;
    held_cmd_nxt = held_cmd_r;
    p0_nxt       = p0_r;
    p1_nxt       = p1_r;
    cmd_nxt      = cmd_r;
    cmd_vld_nxt  = 1'b0;
    wd_nxt       = wd_r;
    wd_vld_nxt   = 1'b0;
    auto_rd_nxt  = auto_rd_r;
    auto_wr_nxt  = auto_wr_r;
    err_nxt      = err_r;
    disp_on_nxt  = disp_on_r;
    case (state_r)
      LCP_IDLE: begin
        if (wr_rise && enable_i) begin
          if (!bus.cd) begin
            if (auto_wr_r) begin
              wd_nxt     = in_byte;
              wd_vld_nxt = 1'b1;
            end else begin
              p1_nxt = p0_r;
              p0_nxt = in_byte;
            end
            state_nxt    = LCP_BUSY;
            busy_cnt_nxt = 8'(lcp_pkg::BUSY_CYC);
          end else if (!in_byte[7] && calc) begin
            held_cmd_nxt = in_byte;
            state_nxt    = LCP_WAIT;
          end else begin
            cmd_nxt      = in_byte;
            cmd_vld_nxt  = 1'b1;
            state_nxt    = LCP_BUSY;
            busy_cnt_nxt = 8'(lcp_pkg::BUSY_CYC);
            if (is_auto(in_byte)) begin
              auto_rd_nxt = in_byte == lcp_pkg::CMD_AUTO_READ;
              auto_wr_nxt = in_byte == lcp_pkg::CMD_AUTO_WRITE;
            end
            if (in_byte == lcp_pkg::CMD_AUTO_RESET) begin
              auto_rd_nxt = 1'b0;
              auto_wr_nxt = 1'b0;
            end
            if (in_byte == lcp_pkg::CMD_PEEK || in_byte == lcp_pkg::CMD_COPY) begin
              err_nxt = peek_fault_i;
            end
            if ((in_byte & lcp_pkg::CMD_DISP_MASK) == lcp_pkg::CMD_DISP_CODE) begin
              disp_on_nxt = in_byte[3:0] != 4'h0;
            end
          end
        end
      end
      LCP_WAIT: begin
        if (!calc) begin
          cmd_nxt      = held_cmd_r;
          cmd_vld_nxt  = 1'b1;
          state_nxt    = LCP_BUSY;
          busy_cnt_nxt = 8'(lcp_pkg::BUSY_CYC);
        end
      end
      LCP_BUSY: begin
        if (busy_cnt_r == 8'h01) begin
          state_nxt = LCP_IDLE;
        end
        busy_cnt_nxt = busy_cnt_r - 8'h01;
      end
      default: begin
        state_nxt = LCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= LCP_IDLE;
      busy_cnt_r <= 8'h00;
      line_cnt_r <= 8'h00;
      held_cmd_r <= 8'h00;
      p0_r       <= 8'h00;
      p1_r       <= 8'h00;
      cmd_r      <= 8'h00;
      cmd_vld_r  <= 1'b0;
      wd_r       <= 8'h00;
      wd_vld_r   <= 1'b0;
      auto_rd_r  <= 1'b0;
      auto_wr_r  <= 1'b0;
      err_r      <= 1'b0;
      disp_on_r  <= 1'b0;
      wr_prev_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      line_cnt_r <= line_cnt_nxt;
      held_cmd_r <= held_cmd_nxt;
      p0_r       <= p0_nxt;
      p1_r       <= p1_nxt;
      cmd_r      <= cmd_nxt;
      cmd_vld_r  <= cmd_vld_nxt;
      wd_r       <= wd_nxt;
      wd_vld_r   <= wd_vld_nxt;
      auto_rd_r  <= auto_rd_nxt;
      auto_wr_r  <= auto_wr_nxt;
      err_r      <= err_nxt;
      disp_on_r  <= disp_on_nxt;
      wr_prev_r  <= wr_prev_nxt;
    end
  end

  // ****************************************
  // Status byte
  // ****************************************
  logic       ready;
  logic       in_auto;
  logic [7:0] status;

  assign ready   = (state_r == LCP_IDLE) && enable_i;
  assign in_auto = auto_rd_r || auto_wr_r;

  always_comb begin
    status = 8'h00;
    status[lcp_pkg::STA_CMD_READY]  = ready && !in_auto;
    status[lcp_pkg::STA_DATA_READY] = ready && !in_auto;
    status[lcp_pkg::STA_AUTO_RD]    = ready && auto_rd_r;
    status[lcp_pkg::STA_AUTO_WR]    = ready && auto_wr_r;
    status[lcp_pkg::STA_UNUSED]     = 1'b0;
    status[lcp_pkg::STA_OPERABLE]   = enable_i;
    status[lcp_pkg::STA_PEEK_ERR]   = err_r;
    status[lcp_pkg::STA_BLINK]      = disp_on_r;
  end

  logic [7:0] dout_r;
  logic [7:0] dout_nxt;

  assign dout_nxt   = bus.cd ? status : 8'h00;
  assign bus.dev_d  = dout_r;
  assign bus.dev_oe = rd_act;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_r <= 8'h00;
    end else begin
      dout_r <= dout_nxt;
    end
  end

  // ****************************************
  // Display RAM address map
  // ****************************************
  logic [15:0] addr_nxt;
  logic [15:0] addr_r;

  always_comb begin
    addr_nxt = scan_addr_i;
    if (dual_scan_i) begin
      addr_nxt = {scan_lower_i, scan_addr_i[lcp_pkg::PANEL_SEL_BIT-1:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= 16'h0000;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  assign ram_addr_o               = addr_r;
  assign mem_select_low_region_o  = addr_r[15:12] == 4'h0 && addr_r <= lcp_pkg::SEL_LOW_TOP;
  assign mem_select_high_region_o = addr_r >= lcp_pkg::SEL_HIGH_BASE && addr_r <= lcp_pkg::SEL_HIGH_TOP;
  assign cmd_o                    = cmd_r;
  assign param0_o                 = p0_r;
  assign param1_o                 = p1_r;
  assign cmd_valid_o              = cmd_vld_r;
  assign wdata_o                  = wd_r;
  assign wdata_valid_o            = wd_vld_r;

endmodule

// File: hw/lcp_host.sv
// Microprocessor end: Wishbone-driven status-checked byte transfers
`timescale 1ns/1ps
module lcp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  lcp_if.host              bus,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o
);

  typedef enum logic [2:0] {
    LCH_IDLE  = 3'b000,
    LCH_SRD   = 3'b001,
    LCH_SCHK  = 3'b010,
    LCH_XFER  = 3'b011,
    LCH_GAP   = 3'b100
  } lch_state_e;

  // Strobe hold counter reload
  function automatic logic [7:0] pulse_len();
    pulse_len = 8'(lcp_pkg::PULSE_CYC);
  endfunction

  lch_state_e  st_r;
  lch_state_e  st_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        cd_r;
  logic        cd_nxt;
  logic        rdop_r;
  logic        rdop_nxt;
  logic [7:0]  wbyte_r;
  logic [7:0]  wbyte_nxt;
  logic [7:0]  rbyte_r;
  logic [7:0]  rbyte_nxt;
  logic [7:0]  stat_r;
  logic [7:0]  stat_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic [1:0]  ists_r;
  logic [1:0]  ists_nxt;
  logic [1:0]  imsk_r;
  logic [1:0]  imsk_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic        ce_n_r;
  logic        ce_n_nxt;
  logic        rd_n_r;
  logic        rd_n_nxt;
  logic        wr_n_r;
  logic        wr_n_nxt;
  logic        bcd_r;
  logic        bcd_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        req;
  logic        go;
  logic        st_ok;
  logic [1:0]  ev;

  assign req = cyc_i && stb_i && !ack_r;
  assign go  = req && we_i && adr_i == lcp_pkg::REG_CTRL && sel_i[0] && dat_i[lcp_pkg::CTRL_GO] && !busy_r;

  // Auto bits replace command/data bits while in auto mode; both normal bits checked together
  always_comb begin
    if (stat_r[lcp_pkg::STA_AUTO_RD] || stat_r[lcp_pkg::STA_AUTO_WR]) begin
      st_ok = rdop_r ? stat_r[lcp_pkg::STA_AUTO_RD] : stat_r[lcp_pkg::STA_AUTO_WR];
    end else begin
      st_ok = stat_r[lcp_pkg::STA_CMD_READY] && stat_r[lcp_pkg::STA_DATA_READY];
    end
  end

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    cd_nxt    = cd_r;
    rdop_nxt  = rdop_r;
    wbyte_nxt = wbyte_r;
    rbyte_nxt = rbyte_r;
    stat_nxt  = stat_r;
    busy_nxt  = busy_r;
    ce_n_nxt  = ce_n_r;
    rd_n_nxt  = rd_n_r;
    wr_n_nxt  = wr_n_r;
    bcd_nxt   = bcd_r;
    oe_nxt    = oe_r;
    ev        = 2'b00;
    case (st_r)
      LCH_IDLE: begin
        if (go) begin
          busy_nxt = 1'b1;
          cd_nxt   = dat_i[lcp_pkg::CTRL_CD];
          rdop_nxt = dat_i[lcp_pkg::CTRL_RD];
          st_nxt   = LCH_SRD;
          cnt_nxt  = pulse_len();
          ce_n_nxt = 1'b0;
          rd_n_nxt = 1'b0;
          wr_n_nxt = 1'b1;
          bcd_nxt  = 1'b1;
        end
      end
      LCH_SRD: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          stat_nxt = bus.dev_d;
          ce_n_nxt = 1'b1;
          rd_n_nxt = 1'b1;
          st_nxt   = LCH_SCHK;
        end
      end
      LCH_SCHK: begin
        if (stat_r[lcp_pkg::STA_PEEK_ERR]) begin
          ev[lcp_pkg::IRQ_ERR] = 1'b1;
        end
        if (st_ok) begin
          st_nxt   = LCH_XFER;
          cnt_nxt  = pulse_len();
          ce_n_nxt = 1'b0;
          bcd_nxt  = cd_r;
          rd_n_nxt = !rdop_r;
          wr_n_nxt = rdop_r;
          oe_nxt   = !rdop_r;
        end else begin
          st_nxt   = LCH_SRD;
          cnt_nxt  = pulse_len();
          ce_n_nxt = 1'b0;
          rd_n_nxt = 1'b0;
        end
      end
      LCH_XFER: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          rbyte_nxt = rdop_r ? bus.dev_d : rbyte_r;
          ce_n_nxt  = 1'b1;
          rd_n_nxt  = 1'b1;
          wr_n_nxt  = 1'b1;
          st_nxt    = LCH_GAP;
        end
      end
      LCH_GAP: begin
        oe_nxt   = 1'b0;
        bcd_nxt  = 1'b1;
        busy_nxt = 1'b0;
        st_nxt   = LCH_IDLE;
        ev[lcp_pkg::IRQ_DONE] = 1'b1;
      end
      default: begin
        st_nxt = LCH_IDLE;
      end
    endcase
    if (req && we_i && adr_i == lcp_pkg::REG_DATA && sel_i[0] && !busy_r) begin
      wbyte_nxt = dat_i[7:0];
    end
  end

  // ****************************************
  // Wishbone slave and interrupt registers
  // ****************************************
  always_comb begin
    ack_nxt  = req;
    ists_nxt = ists_r;
    imsk_nxt = imsk_r;
    rd_nxt   = 32'h0000_0000;
    if (req && we_i && adr_i == lcp_pkg::REG_IRQ_STAT && sel_i[0]) begin
      ists_nxt = ists_r & ~dat_i[1:0];
    end
    if (req && we_i && adr_i == lcp_pkg::REG_IRQ_MASK && sel_i[0]) begin
      imsk_nxt = dat_i[1:0];
    end
    ists_nxt = ists_nxt | ev;
    if (req && !we_i) begin
      case (adr_i)
        lcp_pkg::REG_CTRL:     rd_nxt = {31'h0000_0000, busy_r};
        lcp_pkg::REG_DATA:     rd_nxt = {16'h0000, rbyte_r, wbyte_r};
        lcp_pkg::REG_STAT:     rd_nxt = {24'h00_0000, stat_r};
        lcp_pkg::REG_IRQ_STAT: rd_nxt = {30'h0000_0000, ists_r};
        lcp_pkg::REG_IRQ_MASK: rd_nxt = {30'h0000_0000, imsk_r};
        default:               rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= LCH_IDLE;
      cnt_r   <= 8'h00;
      cd_r    <= 1'b0;
      rdop_r  <= 1'b0;
      wbyte_r <= 8'h00;
      rbyte_r <= 8'h00;
      stat_r  <= 8'h00;
      busy_r  <= 1'b0;
      ists_r  <= 2'b00;
      imsk_r  <= 2'b00;
      ack_r   <= 1'b0;
      rd_r    <= 32'h0000_0000;
      ce_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      wr_n_r  <= 1'b1;
      bcd_r   <= 1'b1;
      oe_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      cd_r    <= cd_nxt;
      rdop_r  <= rdop_nxt;
      wbyte_r <= wbyte_nxt;
      rbyte_r <= rbyte_nxt;
      stat_r  <= stat_nxt;
      busy_r  <= busy_nxt;
      ists_r  <= ists_nxt;
      imsk_r  <= imsk_nxt;
      ack_r   <= ack_nxt;
      rd_r    <= rd_nxt;
      ce_n_r  <= ce_n_nxt;
      rd_n_r  <= rd_n_nxt;
      wr_n_r  <= wr_n_nxt;
      bcd_r   <= bcd_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign bus.ce_n    = ce_n_r;
  assign bus.rd_n    = rd_n_r;
  assign bus.wr_n    = wr_n_r;
  assign bus.cd      = bcd_r;
  assign bus.host_d  = wbyte_r;
  assign bus.host_oe = oe_r;
  assign dat_o       = rd_r;
  assign ack_o       = ack_r;
  assign irq_o       = |(ists_r & imsk_r);

endmodule

// File: test/lcp_chk.sv
// Wire protocol checker for the parallel host port
`timescale 1ns/1ps
module lcp_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       cd,
  input wire logic [7:0] host_d,
  input wire logic       host_oe,
  input wire logic [7:0] dev_d,
  input wire logic       dev_oe
);
  // ****************************************
  // Strobe lengths and last status seen
  // ****************************************
  logic [7:0] rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt, stat_r, stat_nxt;
  logic       wr_ok, rd_ok;

  always_comb begin
    rd_cnt_nxt = rd_n ? 8'h00 : rd_cnt_r + 8'h01;
    wr_cnt_nxt = wr_n ? 8'h00 : wr_cnt_r + 8'h01;
    stat_nxt   = stat_r;
    if (!rd_n && cd) begin
      stat_nxt = dev_d;
    end else if (!wr_n || !rd_n) begin
      // A transfer uses up the status check that allowed it
      stat_nxt = 8'h00;
    end
    wr_ok = (stat_r[0] && stat_r[1]) || stat_r[3];
    rd_ok = (stat_r[0] && stat_r[1]) || stat_r[2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_cnt_r <= 8'h00;
      wr_cnt_r <= 8'h00;
      stat_r   <= 8'h00;
    end else begin
      rd_cnt_r <= rd_cnt_nxt;
      wr_cnt_r <= wr_cnt_nxt;
      stat_r   <= stat_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_OE_CAUSE: assert property (dev_oe |-> !ce_n && !rd_n) else $error("device drives outside a read");
  AST_OE_READ: assert property (!ce_n && !rd_n |-> dev_oe) else $error("device silent during a read");
  AST_BIT4_ZERO: assert property (dev_oe && cd |-> !dev_d[4]) else $error("unused status bit set");
  AST_AUTO_EXCL: assert property (dev_oe && cd |-> !((dev_d[0] || dev_d[1]) && (dev_d[2] || dev_d[3])))
    else $error("normal and auto ready bits both set");
  AST_RD_WIDTH: assert property ($rose(rd_n) |-> rd_cnt_r == lcp_pkg::PULSE_CYC)
    else $error("read strobe length wrong");
  AST_WR_WIDTH: assert property ($rose(wr_n) |-> wr_cnt_r == lcp_pkg::PULSE_CYC)
    else $error("write strobe length wrong");
  AST_RD_ALONE: assert property (!rd_n |-> wr_n && !ce_n) else $error("read strobe malformed");
  AST_WR_HOLD: assert property (!wr_n && !$past(wr_n) |-> $stable(host_d) && host_oe && rd_n && !ce_n)
    else $error("write byte not held");
  AST_WR_READY: assert property ($fell(wr_n) |-> wr_ok) else $error("write without ready status");
  AST_RD_READY: assert property ($fell(rd_n) && !cd |-> rd_ok) else $error("data read without ready status");
endmodule

// File: test/tb.sv
// Testbench joining host and controller ends over the parallel port
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic dual; logic lower; logic [15:0] addr; logic [15:0] exp;} lcp_row_s;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, dual_scan_i, enable_i, peek_fault_i;
  logic        scan_lower_i, mem_select_low_region_o, mem_select_high_region_o, cmd_valid_o, wdata_valid_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd_data;
  logic [15:0] scan_addr_i, ram_addr_o;
  logic [7:0]  cmd_o, param0_o, param1_o, wdata_o;
  logic [7:0]  last_cmd = 8'h00, last_p0 = 8'h00, last_p1 = 8'h00, last_wd = 8'h00;
  int          errors, comparisons, n0;
  int          ncmd = 0;
  lcp_row_s    rows [10] = '{'{1'b0, 1'b0, 16'h0000, 16'h0000}, '{1'b0, 1'b0, 16'h07ff, 16'h07ff},
    '{1'b0, 1'b0, 16'h0800, 16'h0800}, '{1'b0, 1'b0, 16'h0fff, 16'h0fff}, '{1'b0, 1'b0, 16'hffff, 16'hffff},
    '{1'b1, 1'b0, 16'h7fff, 16'h7fff}, '{1'b1, 1'b1, 16'h0123, 16'h8123}, '{1'b1, 1'b1, 16'h7fff, 16'hffff},
    '{1'b1, 1'b0, 16'h07ff, 16'h07ff}, '{1'b1, 1'b0, 16'h8800, 16'h0800}};

  lcp_if u_lcp_if ();
  lcp_host u_lcp_host (.clk_i, .rst_i, .bus(u_lcp_if.host), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .irq_o);
  lcp_dev u_lcp_dev (.clk_i, .rst_i, .bus(u_lcp_if.dev), .dual_scan_i, .enable_i, .peek_fault_i, .scan_addr_i,
    .scan_lower_i, .ram_addr_o, .mem_select_low_region_o, .mem_select_high_region_o, .cmd_o, .param0_o,
    .param1_o, .cmd_valid_o, .wdata_o, .wdata_valid_o);
  lcp_chk u_lcp_chk (.clk_i, .rst_i, .ce_n(u_lcp_if.ce_n), .rd_n(u_lcp_if.rd_n), .wr_n(u_lcp_if.wr_n),
    .cd(u_lcp_if.cd), .host_d(u_lcp_if.host_d), .host_oe(u_lcp_if.host_oe), .dev_d(u_lcp_if.dev_d),
    .dev_oe(u_lcp_if.dev_oe));

  // ****************************************
  // Clock, monitor and tasks
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (cmd_valid_o === 1'b1) begin
      last_cmd <= cmd_o;
      last_p0  <= param0_o;
      last_p1  <= param1_o;
      ncmd     <= ncmd + 1;
    end
    if (wdata_valid_o === 1'b1) begin
      last_wd <= wdata_o;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (ack_o !== 1'b1) errors++;
    rd_data = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic stat(input logic [7:0] exp);
    wb(1'b0, lcp_pkg::REG_STAT, 32'h0);
    chk("status", {24'h0, exp}, rd_data);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, lcp_pkg::REG_CTRL, 32'h0);
      n++;
    end while (rd_data[0] !== 1'b0 && n < 400);
    if (rd_data[0] !== 1'b0) errors++;
    // A held command may issue up to a whole calculation window after the strobe
    repeat (lcp_pkg::CALC_CYC + lcp_pkg::BUSY_CYC) @(posedge clk_i);
  endtask

  task automatic send(input logic cd, input logic rd, input logic [7:0] b);
    wb(1'b1, lcp_pkg::REG_DATA, {24'h0, b});
    wb(1'b1, lcp_pkg::REG_CTRL, {29'h0, rd, cd, 1'b1});
  endtask

  task automatic xfer(input logic cd, input logic rd, input logic [7:0] b);
    send(cd, rd, b);
    wait_idle();
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {cyc_i, stb_i, we_i, dual_scan_i, peek_fault_i, scan_lower_i, adr_i, dat_i, scan_addr_i} = '0;
    {errors, comparisons} = '0;
    sel_i    = 4'h1;
    enable_i = 1'b1;
    rst_i    = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("ce_n", 32'h1, u_lcp_if.ce_n);
    chk("dev_oe", 32'h0, u_lcp_if.dev_oe);
    for (int i = 0; i < 10; i++) begin
      dual_scan_i  <= rows[i].dual;
      scan_lower_i <= rows[i].lower;
      scan_addr_i  <= rows[i].addr;
      repeat (2) @(posedge clk_i);
      chk("ram_addr", rows[i].exp, ram_addr_o);
      if (rows[i].exp[15:12] == 4'h0) begin
        chk("sel_low", rows[i].exp <= lcp_pkg::SEL_LOW_TOP, mem_select_low_region_o);
        chk("sel_high", rows[i].exp >= lcp_pkg::SEL_HIGH_BASE, mem_select_high_region_o);
      end
    end
    wb(1'b1, 4'hf, 32'h5a);
    wb(1'b0, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd_data);
    xfer(1'b0, 1'b0, 8'h11);
    xfer(1'b0, 1'b0, 8'h22);
    xfer(1'b0, 1'b0, 8'h33);
    xfer(1'b1, 1'b0, 8'h24);
    chk("cmd", 32'h24, last_cmd);
    chk("param0", 32'h33, last_p0);
    chk("param1", 32'h22, last_p1);
    stat(8'h23);
    n0 = ncmd;
    for (int k = 0; k < 8; k++) begin
      // Start so that the command strobe ends inside the line-end window
      while (u_lcp_dev.line_cnt_r != 8'(10 + k)) @(posedge clk_i);
      xfer(1'b1, 1'b0, 8'h20 + k[7:0]);
      chk("wait cmd", 32'h20 + k, last_cmd);
    end
    chk("cmd count", n0 + 8, ncmd);
    chk("irq masked", 32'h0, irq_o);
    wb(1'b1, lcp_pkg::REG_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, irq_o);
    wb(1'b1, lcp_pkg::REG_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, irq_o);
    xfer(1'b1, 1'b0, 8'h9c);
    xfer(1'b0, 1'b0, 8'h00);
    stat(8'ha3);
    xfer(1'b1, 1'b0, 8'h90);
    xfer(1'b0, 1'b0, 8'h00);
    stat(8'h23);
    peek_fault_i <= 1'b1;
    xfer(1'b1, 1'b0, lcp_pkg::CMD_PEEK);
    peek_fault_i <= 1'b0;
    xfer(1'b0, 1'b0, 8'h00);
    stat(8'h63);
    wb(1'b0, lcp_pkg::REG_IRQ_STAT, 32'h0);
    chk("error irq", 32'h1, rd_data[1]);
    xfer(1'b1, 1'b0, lcp_pkg::CMD_COPY);
    xfer(1'b0, 1'b1, 8'h00);
    stat(8'h23);
    enable_i <= 1'b0;
    n0 = ncmd;
    send(1'b1, 1'b0, 8'h21);
    repeat (200) @(posedge clk_i);
    wb(1'b0, lcp_pkg::REG_STAT, 32'h0);
    chk("operable", 32'h0, rd_data[5]);
    chk("cmd ready", 32'h0, rd_data[0]);
    chk("held cmd", n0, ncmd);
    enable_i <= 1'b1;
    wait_idle();
    chk("late cmd", 32'h21, last_cmd);
    xfer(1'b1, 1'b0, lcp_pkg::CMD_AUTO_WRITE);
    xfer(1'b0, 1'b0, 8'h55);
    chk("auto data", 32'h55, last_wd);
    xfer(1'b0, 1'b0, 8'haa);
    chk("auto data", 32'haa, last_wd);
    stat(8'h28);
    xfer(1'b1, 1'b0, lcp_pkg::CMD_AUTO_RESET);
    xfer(1'b0, 1'b0, 8'h00);
    stat(8'h23);
    xfer(1'b1, 1'b0, lcp_pkg::CMD_AUTO_READ);
    xfer(1'b0, 1'b1, 8'h00);
    stat(8'h24);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    stat(8'h00);
    chk("dev_oe", 32'h0, u_lcp_if.dev_oe);
    end_of_test();
  end
endmodule
